//--- verilog/gpc_pkg.sv
package gpc_pkg;

   localparam int          NPORT      = 6;
   localparam int          PORT_WIDTH [NPORT] = '{4, 2, 3, 4, 2, 6};

   // port order inside the block: 0, 1, 2, 4, 6, 8
   localparam int          IDX_P0     = 0;
   localparam int          IDX_P1     = 1;
   localparam int          IDX_P2     = 2;
   localparam int          IDX_P4     = 3;
   localparam int          IDX_P6     = 4;
   localparam int          IDX_P8     = 5;

   localparam logic [15:0] LATCH_ADDR [NPORT] =
      '{16'hff00, 16'hff01, 16'hff02, 16'hff04, 16'hff06, 16'hff08};
   localparam logic [15:0] DIR_ADDR   [NPORT] =
      '{16'hff20, 16'hff21, 16'hff22, 16'hff24, 16'hff26, 16'hff28};
   localparam logic [15:0] GRP_PU_ADDR = 16'hff30;
   localparam logic [15:0] P2_PU_ADDR  = 16'hff32;
   localparam logic [15:0] P8_FN_ADDR  = 16'hff58;

   // unimplemented direction bits read back as the reset value
   localparam logic [7:0]  DIR_RST    [NPORT] =
      '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f};
   localparam logic [7:0]  LATCH_RST  = 8'h00;

   localparam logic [7:0]  GRP_PU_RST    = 8'h00;
   localparam logic [7:0]  GRP_PU_MASK   = 8'h13;
   localparam int          GRP_PU_BIT_P0 = 0;
   localparam int          GRP_PU_BIT_P1 = 1;
   localparam int          GRP_PU_BIT_P4 = 4;

   localparam logic [7:0]  P2_PU_RST     = 8'h00;
   localparam logic [7:0]  P2_PU_MASK    = 8'h07;

   localparam logic [7:0]  P8_FN_RST     = 8'h00;
   localparam logic [7:0]  P8_FN_MASK    = 8'h3f;

endpackage : gpc_pkg

//--- verilog/gpc_ch_if.sv
`timescale 1ns/1ps
interface gpc_ch_if;
   logic       wr_latch;
   logic       wr_dir;
   logic [7:0] wdata;
   logic [7:0] pin_in;
   logic [7:0] rd_val;
   logic [7:0] dir_val;
   logic [7:0] latch_val;

   modport ctrl (output wr_latch, output wr_dir, output wdata, output pin_in,
                 input  rd_val,   input  dir_val, input latch_val);
   modport ch   (input  wr_latch, input  wr_dir,  input wdata,  input pin_in,
                 output rd_val,   output dir_val, output latch_val);
endinterface : gpc_ch_if

//--- verilog/gpc_port_ch.sv
`timescale 1ns/1ps
module gpc_port_ch #(
   parameter int         W       = 4,
   parameter logic [7:0] DIR_INI = 8'hff
) (
   input  wire logic clk,
   input  wire logic srst,
   gpc_ch_if.ch      chan
);

   localparam logic [7:0] IMPL = 8'((9'h001 << W) - 9'h001);

   generate
      if (W < 1 || W > 8) begin : g_bad_width
         $error("gpc_port_ch: width must be 1 to 8");
      end
   endgenerate

   logic [7:0] latch_q;
   logic [7:0] dir_q;

   // the latch stores in either mode; only the buffer enable follows direction
   always_ff @(posedge clk) begin
      if (srst) begin
         latch_q <= gpc_pkg::LATCH_RST;
         dir_q   <= DIR_INI;
      end else begin
         if (chan.wr_latch) begin
            latch_q <= chan.wdata & IMPL;
         end
         if (chan.wr_dir) begin
            dir_q <= (chan.wdata & IMPL) | (DIR_INI & ~IMPL);
         end
      end
   end

   // input bits return the pin, output bits the latch
   assign chan.rd_val    = ((dir_q & chan.pin_in) | (~dir_q & latch_q)) & IMPL;
   assign chan.dir_val   = dir_q;
   assign chan.latch_val = latch_q;

endmodule : gpc_port_ch

//--- verilog/gpc_pullup.sv
`timescale 1ns/1ps
module gpc_pullup (
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire logic [7:0]           grp_pu,
   input  wire logic [7:0]           p2_pu,
   input  wire logic [5:0][7:0]      dir,
   output logic      [5:0][7:0]      pull_q
);

   logic [5:0][7:0] pull_d;

   genvar i;
   generate
      for (i = 0; i < gpc_pkg::NPORT; i++) begin : g_port
         // unimplemented direction bits of ports 0,1,4 read as input; keep them free of pull-ups
         localparam logic [7:0] IMPL = 8'((9'h001 << gpc_pkg::PORT_WIDTH[i]) - 9'h001);
         if (i == gpc_pkg::IDX_P0) begin : g_p0
            assign pull_d[i] = {8{grp_pu[gpc_pkg::GRP_PU_BIT_P0]}} & dir[i] & IMPL;
         end else if (i == gpc_pkg::IDX_P1) begin : g_p1
            assign pull_d[i] = {8{grp_pu[gpc_pkg::GRP_PU_BIT_P1]}} & dir[i] & IMPL;
         end else if (i == gpc_pkg::IDX_P4) begin : g_p4
            assign pull_d[i] = {8{grp_pu[gpc_pkg::GRP_PU_BIT_P4]}} & dir[i] & IMPL;
         end else if (i == gpc_pkg::IDX_P2) begin : g_p2
            // connected in any mode, alternate function included
            assign pull_d[i] = p2_pu & gpc_pkg::P2_PU_MASK;
         end else begin : g_none
            assign pull_d[i] = 8'h00;
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         pull_q <= '0;
      end else begin
         pull_q <= pull_d;
      end
   end

endmodule : gpc_pullup

//--- verilog/gpc_port_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - group pull-up enable applies per port 0,1,4 only to input bits.
// - output bits of ports 0,1,4 never get a pull-up, any function.
// - group pull-up register resets to 00h; bits 2,3,5-7 stay zero.
// - port 2 pull-ups per bit, connected in input and output mode.
// - port 2 pull-up bit 1 connects, 0 disconnects; resets 00h; bits 3-7 zero.
// - port 8 function bit 1 selects segment output, 0 port; resets 00h.
// - output mode write stores latch, latch drives pin, held until next write.
// - input mode write updates latch but pin stays undriven.
// - reading an output bit returns the latch, latch unchanged.
// - reading an input bit returns the pin level, latch unchanged.
// - output mode read-modify-write works on latch and drives the result.
// - input mode arithmetic read-modify-write leaves latch undefined, pin unchanged.
// - single-bit port manipulation is a full byte access.
// - direction bit 0 is output with buffer on, 1 is input.
// - reset sets directions ffh, port 8 3fh: all pins input.
module gpc_port_ctrl (
   input  wire logic            clk,
   input  wire logic            srst,
   input  wire logic            bus_req,
   input  wire logic            bus_we,
   input  wire logic            bus_bit,
   input  wire logic [2:0]      bus_bit_pos,
   input  wire logic [15:0]     bus_addr,
   input  wire logic [7:0]      bus_wdata,
   output logic      [7:0]      bus_rdata,
   output logic                 bus_rvalid,
   input  wire logic [5:0][7:0] port_pin_in,
   output logic      [5:0][7:0] port_pin_out,
   output logic      [5:0][7:0] port_pin_oe,
   output logic      [5:0][7:0] port_pullup_en,
   output logic      [5:0]      lcd_segment_outputs
);

   localparam int NP = gpc_pkg::NPORT;

   logic [7:0]         grp_pu_q;
   logic [7:0]         p2_pu_q;
   logic [7:0]         p8_fn_q;
   logic [7:0]         bus_rdata_q;
   logic               bus_rvalid_q;
   logic [NP-1:0][7:0] pin_out_q;
   logic [NP-1:0][7:0] pin_oe_q;
   logic [5:0]         lcd_seg_q;

   logic [NP-1:0]      hit_latch;
   logic [NP-1:0]      hit_dir;
   logic [NP-1:0][7:0] dir_all;
   logic [NP-1:0][7:0] latch_all;
   logic [NP-1:0][7:0] rd_all;
   logic               hit_grp_pu;
   logic               hit_p2_pu;
   logic               hit_p8_fn;
   logic               wr_any;
   logic               rd_only;
   logic [7:0]         cur_byte;
   logic [7:0]         bit_mask;
   logic [7:0]         merged_byte;
   logic [7:0]         wr_byte;

   gpc_ch_if chan [NP] ();

   // a bit operation is carried out as a byte read merged and written back
   assign wr_any      = bus_req & (bus_we | bus_bit);
   assign rd_only     = bus_req & ~bus_we & ~bus_bit;
   assign bit_mask    = 8'(8'h01 << bus_bit_pos);
   assign merged_byte = (cur_byte & ~bit_mask) | ({8{bus_wdata[0]}} & bit_mask);
   assign wr_byte     = bus_bit ? merged_byte : bus_wdata;

   assign hit_grp_pu = (bus_addr == gpc_pkg::GRP_PU_ADDR);
   assign hit_p2_pu  = (bus_addr == gpc_pkg::P2_PU_ADDR);
   assign hit_p8_fn  = (bus_addr == gpc_pkg::P8_FN_ADDR);

   genvar i;
   generate
      for (i = 0; i < NP; i++) begin : g_ch
         assign hit_latch[i]      = (bus_addr == gpc_pkg::LATCH_ADDR[i]);
         assign hit_dir[i]        = (bus_addr == gpc_pkg::DIR_ADDR[i]);
         assign chan[i].wr_latch  = wr_any & hit_latch[i];
         assign chan[i].wr_dir    = wr_any & hit_dir[i];
         assign chan[i].wdata     = wr_byte;
         assign chan[i].pin_in    = port_pin_in[i];
         assign rd_all[i]         = chan[i].rd_val;
         assign dir_all[i]        = chan[i].dir_val;
         assign latch_all[i]      = chan[i].latch_val;

         gpc_port_ch #(
            .W       (gpc_pkg::PORT_WIDTH[i]),
            .DIR_INI (gpc_pkg::DIR_RST[i])
         ) u_ch (
            .clk  (clk),
            .srst (srst),
            .chan (chan[i])
         );
      end
   endgenerate

   // byte seen by a read and by the read half of a bit operation
   always_comb begin
      cur_byte = 8'h00;
      for (int k = 0; k < NP; k++) begin
         if (hit_latch[k]) begin
            cur_byte = rd_all[k];
         end
         if (hit_dir[k]) begin
            cur_byte = dir_all[k];
         end
      end
      if (hit_grp_pu) begin
         cur_byte = grp_pu_q;
      end
      if (hit_p2_pu) begin
         cur_byte = p2_pu_q;
      end
      if (hit_p8_fn) begin
         cur_byte = p8_fn_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         grp_pu_q <= gpc_pkg::GRP_PU_RST;
         p2_pu_q  <= gpc_pkg::P2_PU_RST;
         p8_fn_q  <= gpc_pkg::P8_FN_RST;
      end else begin
         if (wr_any && hit_grp_pu) begin
            grp_pu_q <= wr_byte & gpc_pkg::GRP_PU_MASK;
         end
         if (wr_any && hit_p2_pu) begin
            p2_pu_q <= wr_byte & gpc_pkg::P2_PU_MASK;
         end
         if (wr_any && hit_p8_fn) begin
            p8_fn_q <= wr_byte & gpc_pkg::P8_FN_MASK;
         end
      end
   end

   // read answer one edge after the request; unmapped reads give zero
   always_ff @(posedge clk) begin
      if (srst) begin
         bus_rdata_q  <= 8'h00;
         bus_rvalid_q <= 1'b0;
      end else begin
         bus_rvalid_q <= rd_only;
         if (rd_only) begin
            bus_rdata_q <= cur_byte;
         end
      end
   end

   // pin drivers: buffer on only for output bits; segment pins leave the port
   generate
      for (i = 0; i < NP; i++) begin : g_pin
         logic [7:0] seg_off;
         if (i == gpc_pkg::IDX_P8) begin : g_p8
            assign seg_off = p8_fn_q;
         end else begin : g_gp
            assign seg_off = 8'h00;
         end
         always_ff @(posedge clk) begin
            if (srst) begin
               pin_out_q[i] <= 8'h00;
               pin_oe_q[i]  <= 8'h00;
            end else begin
               pin_out_q[i] <= latch_all[i] & ~seg_off;
               pin_oe_q[i]  <= ~dir_all[i] & ~seg_off
                               & 8'((9'h001 << gpc_pkg::PORT_WIDTH[i]) - 9'h001);
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (srst) begin
         lcd_seg_q <= 6'h00;
      end else begin
         lcd_seg_q <= p8_fn_q[5:0];
      end
   end

   gpc_pullup u_pullup (
      .clk    (clk),
      .srst   (srst),
      .grp_pu (grp_pu_q),
      .p2_pu  (p2_pu_q),
      .dir    (dir_all),
      .pull_q (port_pullup_en)
   );

   assign bus_rdata           = bus_rdata_q;
   assign bus_rvalid          = bus_rvalid_q;
   assign port_pin_out        = pin_out_q;
   assign port_pin_oe         = pin_oe_q;
   assign lcd_segment_outputs = lcd_seg_q;

endmodule : gpc_port_ctrl

//--- sim/gpc_pin_model.sv
`timescale 1ns/1ps
// pins seen from outside: driven, pulled high, or left to the board level
module gpc_pin_model (
   input  wire logic [5:0][7:0] pin_out,
   input  wire logic [5:0][7:0] pin_oe,
   input  wire logic [5:0][7:0] pull_en,
   input  wire logic [5:0][7:0] ext_lvl,
   output logic      [5:0][7:0] pin_lvl
);
   // an enabled pull-up wins over a low drive
   assign pin_lvl = (pin_oe & pin_out) | pull_en | (~pin_oe & ext_lvl);
endmodule : gpc_pin_model

//--- sim/gpc_port_ctrl_props.sv
`timescale 1ns/1ps
module gpc_port_ctrl_props (
   input wire logic            clk,
   input wire logic            srst,
   input wire logic            bus_req,
   input wire logic            bus_we,
   input wire logic            bus_bit,
   input wire logic [2:0]      bus_bit_pos,
   input wire logic [15:0]     bus_addr,
   input wire logic [7:0]      bus_wdata,
   input wire logic [7:0]      bus_rdata,
   input wire logic            bus_rvalid,
   input wire logic [5:0][7:0] port_pin_in,
   input wire logic [5:0][7:0] port_pin_out,
   input wire logic [5:0][7:0] port_pin_oe,
   input wire logic [5:0][7:0] port_pullup_en,
   input wire logic [5:0]      lcd_segment_outputs
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_dir0_wr;
      bus_req && bus_we && !bus_bit && bus_addr == 16'hff20;
   endsequence
   sequence s_quiet0;
      !(bus_req && bus_addr == 16'hff20);
   endsequence
   AST_RVALID: assert property (bus_req && !bus_we && !bus_bit |=> bus_rvalid)
      else $error("read got no valid pulse");
   AST_NO_RVALID: assert property (!(bus_req && !bus_we && !bus_bit) |=> !bus_rvalid)
      else $error("valid pulse without read");
   AST_RDATA_HOLD: assert property ($changed(bus_rdata) |-> bus_rvalid)
      else $error("read data moved outside a read");
   AST_PU_OUT: assert property (((port_pullup_en[0] & port_pin_oe[0])
      | (port_pullup_en[1] & port_pin_oe[1]) | (port_pullup_en[3] & port_pin_oe[3])) == 8'h00)
      else $error("pull-up on an output bit");
   AST_SEG: assert property ((lcd_segment_outputs
      & (port_pin_oe[5][5:0] | port_pin_out[5][5:0])) == 6'h00)
      else $error("segment pin driven as port");
   AST_RST: assert property (disable iff (1'b0) srst |=> port_pin_oe == '0
      && port_pullup_en == '0 && lcd_segment_outputs == 6'h00)
      else $error("outputs not cleared by reset");
   AST_DIR0: assert property (s_dir0_wr ##1 s_quiet0
      |-> ##1 port_pin_oe[0] == (~$past(bus_wdata, 2) & 8'h0f))
      else $error("port 0 not driving after direction write");
   AST_PIN0_HOLD: assert property ($changed(port_pin_out[0])
      |-> $past(bus_req && (bus_we || bus_bit) && bus_addr == 16'hff00, 2))
      else $error("port 0 latch moved without a write");
   AST_PU2_HOLD: assert property ($changed(port_pullup_en[2])
      |-> $past(bus_req && (bus_we || bus_bit) && bus_addr == 16'hff32, 2))
      else $error("port 2 pull-ups moved without a write");
   AST_PU2_RSV: assert property (port_pullup_en[2][7:3] == 5'h00)
      else $error("port 2 pull-up on missing pin");
endmodule : gpc_port_ctrl_props
bind gpc_port_ctrl gpc_port_ctrl_props i_props (.*);

//--- sim/test_port_pin_control_logic.sv
`timescale 1ns/1ps
module test_port_pin_control_logic;
   logic            clk, srst, bus_req, bus_we, bus_bit, bus_rvalid;
   logic [2:0]      bus_bit_pos;
   logic [15:0]     bus_addr;
   logic [7:0]      bus_wdata, bus_rdata, rd;
   logic [5:0][7:0] pin_in, pin_out, pin_oe, pull, ext_lvl;
   logic [5:0]      lcd;
   int              n_errors, n_tests;
   gpc_port_ctrl i_dut (.clk(clk), .srst(srst), .bus_req(bus_req), .bus_we(bus_we),
      .bus_bit(bus_bit), .bus_bit_pos(bus_bit_pos), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
      .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
      .port_pullup_en(pull), .lcd_segment_outputs(lcd));
   gpc_pin_model i_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull),
      .ext_lvl(ext_lvl), .pin_lvl(pin_in));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task acc(input logic [15:0] a, input logic [7:0] d, input logic we, input logic bt);
      @(negedge clk);
      {bus_req, bus_addr, bus_wdata, bus_we, bus_bit} = {1'b1, a, d, we, bt};
      @(negedge clk);
      bus_req = 1'b0;
      rd = bus_rdata;
      if (!we && !bt) chk({7'h00, bus_rvalid}, 8'h01);
   endtask : acc
   task wr(input logic [15:0] a, input logic [7:0] d);
      acc(a, d, 1'b1, 1'b0);
   endtask : wr
   task rdc(input logic [15:0] a, input logic [7:0] exp);
      acc(a, 8'h00, 1'b0, 1'b0);
      chk(rd, exp);
   endtask : rdc
   task settle;
      repeat (2) @(negedge clk);
   endtask : settle
   task t_reset;
      for (int i = 0; i < gpc_pkg::NPORT; i++) begin
         rdc(gpc_pkg::DIR_ADDR[i], gpc_pkg::DIR_RST[i]);
      end
      rdc(16'hff30, 8'h00);
      rdc(16'hff32, 8'h00);
      rdc(16'hff58, 8'h00);
      rdc(16'hff10, 8'h00);
      chk(pin_oe[0], 8'h00);
   endtask : t_reset
   task t_out;
      wr(16'hff20, 8'hf0);
      wr(16'hff00, 8'h0a);
      settle();
      chk(pin_out[0], 8'h0a);
      chk(pin_oe[0], 8'h0f);
      rdc(16'hff00, 8'h0a);
      rdc(16'hff20, 8'hf0);
   endtask : t_out
   task t_in;
      ext_lvl[1] = 8'h02;
      wr(16'hff01, 8'h03);
      settle();
      chk(pin_oe[1], 8'h00);
      chk(pin_in[1], 8'h02);
      rdc(16'hff01, 8'h02);
      wr(16'hff21, 8'hfc);
      settle();
      chk(pin_oe[1], 8'h03);
      rdc(16'hff01, 8'h03);
   endtask : t_in
   task t_pull;
      wr(16'hff20, 8'hfc);
      wr(16'hff30, 8'hff);
      settle();
      rdc(16'hff30, 8'h13);
      chk(pull[0], 8'h0c);
      chk(pull[1], 8'h00);
      chk(pull[3], 8'h0f);
      wr(16'hff22, 8'hfe);
      wr(16'hff32, 8'hff);
      settle();
      rdc(16'hff32, 8'h07);
      chk(pull[2], 8'h07);
      wr(16'hff32, 8'h05);
      wr(16'hff30, 8'h00);
      settle();
      chk(pull[2], 8'h05);
      chk(pull[3], 8'h00);
   endtask : t_pull
   task t_bit;
      ext_lvl[3] = 8'h0a;
      wr(16'hff24, 8'hfe);
      wr(16'hff04, 8'h00);
      bus_bit_pos = 3'h2;
      acc(16'hff04, 8'h01, 1'b0, 1'b1);
      wr(16'hff24, 8'hf0);
      settle();
      chk(pin_out[3], 8'h0e);
   endtask : t_bit
   task t_alt;
      ext_lvl[4] = 8'h02;
      wr(16'hff26, 8'hfe);
      wr(16'hff06, 8'h00);
      settle();
      chk(pin_oe[4], 8'h01);
      chk(pin_out[4], 8'h00);
      rdc(16'hff06, 8'h02);
   endtask : t_alt
   task t_seg;
      wr(16'hff28, 8'h00);
      wr(16'hff08, 8'h3f);
      settle();
      chk(pin_oe[5], 8'h3f);
      chk(pin_out[5], 8'h3f);
      wr(16'hff58, 8'hff);
      settle();
      rdc(16'hff58, 8'h3f);
      chk({2'b00, lcd}, 8'h3f);
      chk(pin_oe[5], 8'h00);
      chk(pin_out[5], 8'h00);
   endtask : t_seg
   task test_done;
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      test_done();
   end
   initial begin
      {bus_req, bus_we, bus_bit, bus_bit_pos, bus_addr, bus_wdata} = '0;
      srst = 1'b1;
      ext_lvl = '0;
      n_errors = 0;
      n_tests = 0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_out();
      t_in();
      t_pull();
      t_bit();
      t_alt();
      t_seg();
      test_done();
   end
endmodule : test_port_pin_control_logic
